// ---- pcs_pkg.sv ----
// Shared constants and types for the program counter and return stack
package pcs_pkg;

   // ----------------------------------------------------------------
   // Counter geometry
   // ----------------------------------------------------------------
   localparam int PC_W = 13;
   localparam int LOW_W = 8;
   localparam int LATCH_W = 5;
   localparam int JUMP_W = 11;
   localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
   localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
   localparam logic [LATCH_W-1:0] LATCH_RESET = 5'h00;

   // ----------------------------------------------------------------
   // Return stack geometry
   // ----------------------------------------------------------------
   localparam int STACK_DEPTH = 8;
   localparam int SP_W = 3;
   localparam logic [SP_W-1:0] SP_RESET = 3'h0;

   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   localparam int REG_ADDR_W = 2;
   localparam logic [REG_ADDR_W-1:0] OFS_LOW = 2'h0;
   localparam logic [REG_ADDR_W-1:0] OFS_LATCH = 2'h1;
   localparam logic [LOW_W-1:0] RDATA_RESET = 8'h00;

   // Sequencing request from the decoder, sampled with step_i
   typedef enum logic [2:0] {
      PCS_OP_SEQ = 3'h0,
      PCS_OP_BRANCH = 3'h1,
      PCS_OP_CALL = 3'h2,
      PCS_OP_RETURN = 3'h3,
      PCS_OP_IRQ = 3'h4
   } pcs_op_t;

endpackage : pcs_pkg

// ---- pcs_stack_if.sv ----
// Port bundle between the sequencer and its return-address memory
`timescale 1ns/1ps
interface pcs_stack_if;
   import pcs_pkg::*;
   logic wr_en;
   logic [SP_W-1:0] wr_addr;
   logic [PC_W-1:0] wr_data;
   logic [SP_W-1:0] rd_addr;
   logic [PC_W-1:0] rd_data;

   modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr,
      input rd_data);
   modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr,
      output rd_data);
endinterface : pcs_stack_if

// ---- pcs_stack_mem.sv ----
// Return-address memory with registered read port and write forwarding
`timescale 1ns/1ps
module pcs_stack_mem
   import pcs_pkg::*;
#(
   parameter int DEPTH = STACK_DEPTH
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   pcs_stack_if.mem stk
);

   logic [PC_W-1:0] entry [DEPTH];
   logic [PC_W-1:0] next_rd_data;

   // ----------------------------------------------------------------
   // Storage, one word per entry
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++)
      begin : g_entry
         logic [PC_W-1:0] next_word;
         // Contents need no reset; a stale pop just returns old data
         always_comb
         begin
            next_word = entry[gi];
            if (stk.wr_en && (stk.wr_addr == SP_W'(gi)))
               next_word = stk.wr_data;
         end
         always_ff @(posedge clk_i)
         begin
            entry[gi] <= next_word;
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   // Forward a same-cycle write so the new top is valid next cycle
   always_comb
   begin
      next_rd_data = entry[stk.rd_addr];
      if (stk.wr_en && (stk.wr_addr == stk.rd_addr))
         next_rd_data = stk.wr_data;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         stk.rd_data <= PC_RESET;
      else
         stk.rd_data <= next_rd_data;
   end

endmodule : pcs_stack_mem

// ---- pcs_program_counter.sv ----
// Program counter sequencer with paging latch and circular return stack
//
// Functional notes
// - Counter is 13 bits and addresses one program word.
// - Counter low byte is a software read/write register.
// - Software reaches the upper five counter bits only through the high latch.
// - Any reset clears the whole counter to zero.
// - Low byte write loads latch bits 4..0 into the upper bits.
// - Branch and call use 11 instruction bits plus latch bits 4..3.
// - Eight-entry, 13-bit return stack outside both address spaces.
// - Stack pointer has no software access.
// - Calls and taken interrupts push the return address.
// - All return kinds pop and load the full 13-bit counter.
// - Push and pop never change the high latch.
// - Stack is circular; the ninth push overwrites the oldest entry.
// - No overflow or underflow indication exists.
// - Counter plus paging reach a continuous 8K-word space.
// - High latch is only a holding register for the upper bits.
// - Taken interrupt pushes, then loads the fixed vector.
`timescale 1ns/1ps
module pcs_program_counter
   import pcs_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic step_i,
   input wire pcs_op_t op_i,
   input wire logic [JUMP_W-1:0] target_i,
   input wire logic [REG_ADDR_W-1:0] reg_addr_i,
   input wire logic [LOW_W-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [LOW_W-1:0] reg_rdata_o,
   output logic [PC_W-1:0] pc_o
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [PC_W-1:0] pc;
   logic [PC_W-1:0] next_pc;
   logic [LATCH_W-1:0] latch;
   logic [LATCH_W-1:0] next_latch;
   logic [SP_W-1:0] sp;
   logic [SP_W-1:0] next_sp;
   logic [LOW_W-1:0] rdata;
   logic [LOW_W-1:0] next_rdata;
   logic low_wr;
   logic latch_wr;
   logic push;
   logic pop;
   logic [PC_W-1:0] push_data;

   pcs_stack_if stk ();

   // Stack storage lives apart from any register address
   pcs_stack_mem #(
      .DEPTH(STACK_DEPTH)
   ) u_stack (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .stk(stk)
   );

   // ----------------------------------------------------------------
   // Register decode
   // ----------------------------------------------------------------
   assign low_wr = reg_wr_i && (reg_addr_i == OFS_LOW);
   assign latch_wr = reg_wr_i && (reg_addr_i == OFS_LATCH);

   // ----------------------------------------------------------------
   // Counter sequencing
   // ----------------------------------------------------------------
   // A low-byte write is the instruction's own effect, so it beats step_i
   always_comb
   begin
      next_pc = pc;
      push = 1'b0;
      pop = 1'b0;
      push_data = pc + 13'h0001;
      if (low_wr)
      begin
         // Whole latch into upper bits; no carry from the low byte
         next_pc = {latch, reg_wdata_i};
      end
      else if (step_i)
      begin
         case (op_i)
            PCS_OP_SEQ:
               next_pc = pc + 13'h0001;
            PCS_OP_BRANCH:
               next_pc = {latch[4:3], target_i};
            PCS_OP_CALL:
            begin
               push = 1'b1;
               next_pc = {latch[4:3], target_i};
            end
            PCS_OP_RETURN:
            begin
               // Covers plain, literal and interrupt returns alike
               pop = 1'b1;
               next_pc = stk.rd_data;
            end
            PCS_OP_IRQ:
            begin
               // Interrupted instruction has not run, so return to it
               push = 1'b1;
               push_data = pc;
               next_pc = IRQ_VECTOR;
            end
            default:
               next_pc = pc + 13'h0001;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Stack pointer and high latch
   // ----------------------------------------------------------------
   // Pointer wraps freely; no flag watches it, by design
   always_comb
   begin
      next_sp = sp;
      if (push)
         next_sp = sp + 3'h1;
      else if (pop)
         next_sp = sp - 3'h1;
      // Only a software write touches the latch, never push or pop
      next_latch = latch;
      if (latch_wr)
         next_latch = reg_wdata_i[LATCH_W-1:0];
   end

   // Memory port: write at pointer, prefetch the new top for a pop
   assign stk.wr_en = push;
   assign stk.wr_addr = sp;
   assign stk.wr_data = push_data;
   assign stk.rd_addr = next_sp - 3'h1;

   // ----------------------------------------------------------------
   // Read data, valid only in the cycle after the strobe
   // ----------------------------------------------------------------
   // Pointer has no address here, so it can never be read
   always_comb
   begin
      next_rdata = RDATA_RESET;
      if (reg_rd_i)
      begin
         case (reg_addr_i)
            OFS_LOW:
               next_rdata = pc[LOW_W-1:0];
            OFS_LATCH:
               next_rdata = {3'h0, latch};
            default:
               next_rdata = RDATA_RESET;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pc <= PC_RESET;
         latch <= LATCH_RESET;
         sp <= SP_RESET;
         rdata <= RDATA_RESET;
      end
      else
      begin
         pc <= next_pc;
         latch <= next_latch;
         sp <= next_sp;
         rdata <= next_rdata;
      end
   end

   assign pc_o = pc;
   assign reg_rdata_o = rdata;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_push;
      step_i && !low_wr && (op_i == PCS_OP_CALL);
   endsequence

   sequence s_pop;
      step_i && !low_wr && (op_i == PCS_OP_RETURN);
   endsequence

   sequence s_call_then_return;
      s_push ##1 s_pop;
   endsequence

   a_reset_clears_pc: assert property (
      @(posedge clk_i) $past(rst_i) |-> (pc_o == PC_RESET))
      else $error("counter not zero after reset");

   a_low_write_load: assert property (
      @(posedge clk_i) disable iff (rst_i)
      low_wr |=> (pc_o == {$past(latch), $past(reg_wdata_i)}))
      else $error("low byte write did not load latch and data");

   a_branch_paging: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (step_i && !low_wr && (op_i == PCS_OP_BRANCH))
      |=> (pc_o == {$past(latch[4:3]), $past(target_i)}))
      else $error("branch target not built from page bits");

   a_call_push_value: assert property (
      @(posedge clk_i) disable iff (rst_i)
      s_push |-> (stk.wr_en && (stk.wr_data == pc_o + 13'h0001)))
      else $error("call did not push next address");

   a_irq_vector_load: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (step_i && !low_wr && (op_i == PCS_OP_IRQ))
      |-> stk.wr_en && (stk.wr_data == pc_o) ##1 (pc_o == IRQ_VECTOR))
      else $error("interrupt did not push and vector");

   a_call_return_pair: assert property (
      @(posedge clk_i) disable iff (rst_i)
      s_call_then_return |=> (pc_o == $past(pc_o, 2) + 13'h0001))
      else $error("return did not restore call address");

   a_latch_kept_stack: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (step_i && !low_wr && !latch_wr
         && (op_i inside {PCS_OP_CALL, PCS_OP_RETURN, PCS_OP_IRQ})) |=> $stable(latch))
      else $error("stack operation changed the latch");

   a_seq_advance_one: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (step_i && !low_wr && (op_i == PCS_OP_SEQ))
      |=> (pc_o == $past(pc_o) + 13'h0001))
      else $error("counter did not advance by one");

   a_read_low_byte: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (reg_rd_i && (reg_addr_i == OFS_LOW)) |=> (reg_rdata_o == $past(pc_o[7:0])))
      else $error("low byte read returned wrong value");

   a_read_idle_zero: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !reg_rd_i |=> (reg_rdata_o == RDATA_RESET))
      else $error("read data present without a read");

   a_sp_wraps_push: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (step_i && !low_wr && (op_i inside {PCS_OP_CALL, PCS_OP_IRQ}) && (sp == 3'h7))
      |=> (sp == 3'h0))
      else $error("stack pointer did not wrap on push");

   // ----------------------------------------------------------------
   // Pointer and register port checks
   // ----------------------------------------------------------------
   // Interrupt entry on its own, so its push can be watched apart from calls
   sequence s_irq;
      step_i && !low_wr && (op_i == PCS_OP_IRQ);
   endsequence

   // First edges after release still see the cleared state
   a_reset_clears_state: assert property (
      @(posedge clk_i) $past(rst_i)
      |-> (sp == SP_RESET) && (latch == LATCH_RESET) && (reg_rdata_o == RDATA_RESET))
      else $error("pointer, latch or read data not cleared by reset");

   a_call_push_step: assert property (
      @(posedge clk_i) disable iff (rst_i)
      s_push |=> (sp == $past(sp) + 3'h1))
      else $error("call did not advance the stack pointer");

   a_irq_push_step: assert property (
      @(posedge clk_i) disable iff (rst_i)
      s_irq |=> (sp == $past(sp) + 3'h1))
      else $error("interrupt did not advance the stack pointer");

   a_pop_pointer_step: assert property (
      @(posedge clk_i) disable iff (rst_i)
      s_pop |=> (sp == $past(sp) - 3'h1))
      else $error("return did not step the stack pointer back");

   // Underflow is silent: the pointer simply wraps to the top entry
   a_pop_wraps_pointer: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (step_i && !low_wr && (op_i == PCS_OP_RETURN) && (sp == 3'h0)) |=> (sp == 3'h7))
      else $error("stack pointer did not wrap on pop");

   // A low byte write beats any step, so the stack must not move
   a_low_write_wins: assert property (
      @(posedge clk_i) disable iff (rst_i)
      low_wr |=> $stable(sp))
      else $error("stack moved during a low byte write");

   a_latch_write_value: assert property (
      @(posedge clk_i) disable iff (rst_i)
      latch_wr |=> (latch == $past(reg_wdata_i[LATCH_W-1:0])))
      else $error("latch did not take the written bits");

   // The latch only holds bits; writing it alone never moves the counter
   a_latch_holds_pc: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (latch_wr && !step_i) |=> $stable(pc_o))
      else $error("latch write changed the counter");

   a_read_latch_value: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (reg_rd_i && (reg_addr_i == OFS_LATCH)) |=> (reg_rdata_o == {3'h0, $past(latch)}))
      else $error("latch read returned wrong value");

   a_unmapped_read_zero: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (reg_rd_i && (reg_addr_i != OFS_LOW) && (reg_addr_i != OFS_LATCH))
      |=> (reg_rdata_o == RDATA_RESET))
      else $error("unmapped read returned data");

endmodule : pcs_program_counter

// ---- pcs_dec_model.sv ----
// Decoder-side model that hands one instruction request per call to the sequencer
`timescale 1ns/1ps
module pcs_dec_model
   import pcs_pkg::*;
(
   input wire logic clk_i,
   output logic step_o,
   output pcs_op_t op_o,
   output logic [JUMP_W-1:0] target_o
);
   // Idle state: no instruction and a target pattern that is clearly not a real one
   initial
   begin
      step_o = 1'b0;
      op_o = PCS_OP_SEQ;
      target_o = 11'h7ff;
   end

   // ----------------------------------------------------------------
   // Instruction issue
   // ----------------------------------------------------------------
   // Target holds only page-relative bits; the caller sets page bits first
   // When last is clear the step stays high so the next call is back to back
   task automatic run(input pcs_op_t op, input logic [JUMP_W-1:0] tgt, input bit last);
      step_o <= 1'b1;
      op_o <= op;
      target_o <= tgt;
      @(posedge clk_i);
      if (last)
      begin
         step_o <= 1'b0;
         target_o <= ~tgt; // Released target must not look valid
         @(posedge clk_i);
      end
   endtask : run
endmodule : pcs_dec_model

// ---- tb.sv ----
// Self-checking bench for the program counter sequencer
`timescale 1ns/1ps
`define CHK(nm, exp, act) \
   begin \
      compares++; \
      if ((act) !== (exp)) \
      begin \
         err_count++; \
         $display("wrong value %s expected %h seen %h", nm, exp, act); \
      end \
   end
module tb;
   import pcs_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [REG_ADDR_W-1:0] reg_addr_i = 2'h0;
   logic [LOW_W-1:0] reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [LOW_W-1:0] reg_rdata_o;
   logic [PC_W-1:0] pc_o;
   logic step;
   pcs_op_t op;
   logic [JUMP_W-1:0] target;
   logic [LOW_W-1:0] rd;
   int err_count = 0;
   int compares = 0;

   pcs_dec_model dec (.clk_i(clk_i), .step_o(step), .op_o(op), .target_o(target));
   pcs_program_counter uut (.clk_i(clk_i), .rst_i(rst_i), .step_i(step), .op_i(op),
      .target_i(target), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pc_o(pc_o));

   // 40 MHz core clock
   always #12.5 clk_i = ~clk_i;

   // ----------------------------------------------------------------
   // Bus and reset helpers
   // ----------------------------------------------------------------
   task automatic do_reset(input int n);
      rst_i <= 1'b1;
      repeat (n) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask : do_reset

   // Gap cycle after each strobe so a strobe is never lowered and raised in one step
   task automatic reg_write(input logic [REG_ADDR_W-1:0] a, input logic [LOW_W-1:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
      @(posedge clk_i);
   endtask : reg_write

   // Read data stand only in the cycle after the strobe
   task automatic reg_read(input logic [REG_ADDR_W-1:0] a, output logic [LOW_W-1:0] d);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1 d = reg_rdata_o;
      @(posedge clk_i);
   endtask : reg_read

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      `CHK("reset pc", 13'h0000, pc_o)
      reg_read(OFS_LOW, rd);
      `CHK("reset low byte", 8'h00, rd)
      dec.run(PCS_OP_SEQ, 11'h000, 0);
      dec.run(PCS_OP_SEQ, 11'h000, 0);
      dec.run(PCS_OP_SEQ, 11'h000, 1);
      `CHK("seq pc", 13'h0003, pc_o)
      reg_write(OFS_LATCH, 8'hea);
      reg_read(OFS_LATCH, rd);
      `CHK("latch bits", 8'h0a, rd)
      `CHK("upper untouched", 13'h0003, pc_o)
      reg_write(OFS_LOW, 8'h34);
      `CHK("low write pc", 13'h0a34, pc_o)
      reg_read(OFS_LOW, rd);
      `CHK("low readback", 8'h34, rd)
      // Computed jump past the page end: the sum wraps inside the low byte
      reg_write(OFS_LOW, 8'h34 + 8'hd0);
      `CHK("no carry upward", 13'h0a04, pc_o)
      reg_write(2'h3, 8'hff);
      reg_read(2'h2, rd);
      `CHK("unmapped read", 8'h00, rd)
      reg_read(OFS_LATCH, rd);
      `CHK("latch after unmapped", 8'h0a, rd)
   endtask : t_regs

   task automatic t_branch();
      reg_write(OFS_LATCH, 8'h08);
      dec.run(PCS_OP_BRANCH, 11'h123, 1);
      `CHK("branch pc", 13'h0923, pc_o)
      dec.run(PCS_OP_CALL, 11'h456, 1);
      `CHK("call pc", 13'h0c56, pc_o)
      dec.run(PCS_OP_CALL, 11'h7ff, 0);
      dec.run(PCS_OP_RETURN, 11'h000, 1);
      `CHK("quick return", 13'h0c57, pc_o)
      dec.run(PCS_OP_RETURN, 11'h000, 1);
      `CHK("outer return", 13'h0924, pc_o)
      reg_read(OFS_LATCH, rd);
      `CHK("latch kept", 8'h08, rd)
      dec.run(PCS_OP_IRQ, 11'h3ff, 1);
      `CHK("vector", IRQ_VECTOR, pc_o)
      dec.run(PCS_OP_SEQ, 11'h000, 1);
      dec.run(PCS_OP_RETURN, 11'h000, 1);
      `CHK("irq return", 13'h0924, pc_o)
   endtask : t_branch

   // Nine calls then nine returns: oldest entry lost, second pop wraps the pointer, last pop rereads the ninth call's address
   task automatic t_wrap();
      reg_write(OFS_LATCH, 8'h00);
      reg_write(OFS_LOW, 8'h00);
      for (int k = 0; k < 9; k++)
         dec.run(PCS_OP_CALL, 11'(16 * (k + 1)), 1);
      for (int j = 0; j < 9; j++)
      begin
         dec.run(PCS_OP_RETURN, 11'h000, 1);
         `CHK("stack pop", 13'(16 * (j < 8 ? 8 - j : 8) + 1), pc_o)
      end
   endtask : t_wrap

   task automatic t_top_reset();
      reg_write(OFS_LATCH, 8'h1f);
      reg_write(OFS_LOW, 8'hff);
      `CHK("top word", 13'h1fff, pc_o)
      dec.run(PCS_OP_SEQ, 11'h000, 1);
      `CHK("counter wrap", 13'h0000, pc_o)
      dec.run(pcs_op_t'(3'h5), 11'h000, 1);
      `CHK("spare op advances", 13'h0001, pc_o)
      dec.run(PCS_OP_SEQ, 11'h000, 1);
      do_reset(2);
      `CHK("mid reset pc", 13'h0000, pc_o)
      reg_read(OFS_LATCH, rd);
      `CHK("mid reset latch", 8'h00, rd)
   endtask : t_top_reset

   // ----------------------------------------------------------------
   // Verdict and run control
   // ----------------------------------------------------------------
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : finish_test

   // Whole run is about a hundred cycles; thirty times that means a hang
   initial
   begin
      repeat (3000) @(posedge clk_i);
      err_count++;
      finish_test();
   end

   initial
   begin
      do_reset(5);
      t_regs();
      t_branch();
      t_wrap();
      t_top_reset();
      finish_test();
   end
endmodule : tb
